// *** pkg/amc_pkg.sv ***
// Constants, codes and carrier types for the converter configuration block
package amc_pkg;
   // Bus word layout: two address bits above ten configuration bits
   localparam int BUS_W = 12;
   localparam int CFG_W = 10;
   localparam int ADDR_LSB = 10;
   // Register selects carried in bits 11:10 of the written word
   localparam logic [1:0] ADDR_INPUT_REF = 2'h0;
   localparam logic [1:0] ADDR_RESET_FMT = 2'h1;
   // Reset values of both configuration registers
   localparam logic [9:0] INPUT_REF_RESET = 10'h020;
   localparam logic [9:0] RESET_FMT_RESET = 10'h030;
   // Field positions of the input and reference register
   localparam int REF_SELECT_BIT = 0;
   localparam int POWER_DOWN_BIT = 2;
   localparam int CHAN_LSB = 3;
   localparam int CHAN_MSB = 7;
   localparam int TEST_LSB = 8;
   localparam int TEST_MSB = 9;
   // Field positions of the reset, format and calibration register
   localparam int DEVICE_RESET_BIT = 0;
   localparam int SYNC_RESET_BIT = 1;
   localparam int RW_STYLE_BIT = 6;
   localparam int FORMAT_BIT = 7;
   localparam int OFFSET_CAL_BIT = 8;
   // Defined channel codes in bits 7:3 (scan, differential_count_high, differential_count_low, pick1, pick0)
   localparam logic [4:0] CHAN_CODE_POS = 5'h00;
   localparam logic [4:0] CHAN_CODE_NEG = 5'h01;
   localparam logic [4:0] CHAN_CODE_DIFF = 5'h04;
   localparam logic [4:0] CHAN_CODE_SCAN = 5'h11;
   // Channel configuration, Gray coded
   typedef enum logic [2:0] {
      CHAN_POS = 3'h0,
      CHAN_NEG = 3'h1,
      CHAN_DIFF = 3'h3,
      CHAN_SCAN = 3'h2,
      CHAN_RSVD = 3'h6
   } amc_chan_mode_t;
   // Source that the converter digitises
   typedef enum logic [1:0] {
      SRC_NORMAL = 2'h0,
      SRC_UPPER = 2'h1,
      SRC_MID = 2'h2,
      SRC_LOWER = 2'h3
   } amc_conv_src_t;
   // Decoded configuration handed to the converter core
   typedef struct packed {
      logic ref_external;
      logic power_down;
      amc_chan_mode_t chan_mode;
      amc_conv_src_t conv_src;
      logic test_active;
      logic binary_format;
      logic offset_cal;
      logic rw_combined;
      logic device_reset;
   } amc_cfg_t;
endpackage

// *** hw/amc_config_regs.sv ***
// Write-only configuration registers and pin decode of the converter
`timescale 1ns/1ps
module amc_config_regs
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic [amc_pkg::BUS_W-1:0] i_data,
   input wire logic i_cs0_n,
   input wire logic i_cs1,
   input wire logic i_wr_n,
   input wire logic i_rd_n,
   input wire logic i_conv_strobe,
   output amc_pkg::amc_cfg_t o_cfg,
   output logic o_sync_reset,
   output logic o_read_en,
   output logic o_write_taken,
   output logic o_active_input
);
   import amc_pkg::*;

   logic [CFG_W-1:0] input_ref_r; // Input and reference register
   logic [CFG_W-1:0] reset_fmt_r; // Reset, format and calibration register
   logic wr_act_d_r; // Write strobe seen last cycle
   logic sync_r; // Sync generator reset pulse
   logic neg_sel_r; // Negative input currently converted
   logic scan_prev_r; // Autoscan was already running
   amc_cfg_t cfg_r; // Registered decoded configuration
   amc_cfg_t cfg_nxt;
   logic sel; // Both chip selects asserted
   logic wr_act; // Write strobe active while selected
   logic rd_act; // Read strobe active while selected
   logic wr_take; // Single cycle: a word is taken
   logic [1:0] addr; // Register select of the word on the bus
   logic [CFG_W-1:0] wdata; // Configuration bits of the word
   logic take_input; // Write aimed at the input register
   logic take_fmt; // Write aimed at the format register
   logic rw_style; // Combined read/write line in use

   // Pin decode; the write line is active low in either style
   assign sel = ~i_cs0_n & i_cs1;
   assign rw_style = reset_fmt_r[RW_STYLE_BIT];
   assign wr_act = sel & ~i_wr_n;
   // Combined style reads while the write line is high, ignoring read strobe
   assign rd_act = sel & (rw_style ? i_wr_n : ~i_rd_n);
   assign addr = i_data[BUS_W-1:ADDR_LSB];
   assign wdata = i_data[CFG_W-1:0];
   // Take a word once per strobe, on its leading edge
   assign wr_take = wr_act & ~wr_act_d_r;
   assign take_input = wr_take && (addr == ADDR_INPUT_REF);
   assign take_fmt = wr_take && (addr == ADDR_RESET_FMT);
   // Addresses 10 and 11 match neither take term, so nothing changes

   // Strobe history for the edge detector
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         wr_act_d_r <= 1'b0;
      end
      else
      begin
         wr_act_d_r <= wr_act;
      end
   end

   // Input and reference register; held at reset while the device reset
   // bit is set, so writes to it are lost until that bit is cleared
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         input_ref_r <= INPUT_REF_RESET;
      end
      else if (take_fmt && wdata[DEVICE_RESET_BIT])
      begin
         input_ref_r <= INPUT_REF_RESET;
      end
      else if (reset_fmt_r[DEVICE_RESET_BIT])
      begin
         input_ref_r <= INPUT_REF_RESET;
      end
      else if (take_input)
      begin
         // Reserved channel codes are stored; the host must avoid them
         input_ref_r <= wdata;
      end
   end

   // Reset, format and calibration register
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         reset_fmt_r <= RESET_FMT_RESET;
      end
      else if (take_fmt)
      begin
         if (wdata[DEVICE_RESET_BIT])
         begin
            // Restore defaults but keep the reset bit, which holds the part
            reset_fmt_r <= RESET_FMT_RESET | CFG_W'(1);
         end
         else
         begin
            reset_fmt_r <= wdata;
         end
      end
   end

   // Sync generator reset: one pulse per write with the bit set
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         sync_r <= 1'b0;
      end
      else
      begin
         sync_r <= take_fmt && wdata[SYNC_RESET_BIT];
      end
   end

   // Decode register fields into the configuration carrier
   always_comb
   begin
      cfg_nxt = '0;
      cfg_nxt.ref_external = input_ref_r[REF_SELECT_BIT];
      cfg_nxt.power_down = input_ref_r[POWER_DOWN_BIT];
      case (input_ref_r[CHAN_MSB:CHAN_LSB])
         CHAN_CODE_POS: cfg_nxt.chan_mode = CHAN_POS;
         CHAN_CODE_NEG: cfg_nxt.chan_mode = CHAN_NEG;
         CHAN_CODE_DIFF: cfg_nxt.chan_mode = CHAN_DIFF;
         CHAN_CODE_SCAN: cfg_nxt.chan_mode = CHAN_SCAN;
         default: cfg_nxt.chan_mode = CHAN_RSVD; // Reserved code
      endcase
      cfg_nxt.conv_src = amc_conv_src_t'(input_ref_r[TEST_MSB:TEST_LSB]);
      // Any test setting replaces the inputs by a fixed voltage
      cfg_nxt.test_active = |input_ref_r[TEST_MSB:TEST_LSB];
      cfg_nxt.binary_format = reset_fmt_r[FORMAT_BIT];
      cfg_nxt.offset_cal = reset_fmt_r[OFFSET_CAL_BIT];
      cfg_nxt.rw_combined = reset_fmt_r[RW_STYLE_BIT];
      cfg_nxt.device_reset = reset_fmt_r[DEVICE_RESET_BIT];
   end

   // Configuration outputs come from flip-flops
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         cfg_r <= '0;
         cfg_r.chan_mode <= CHAN_DIFF;
      end
      else
      begin
         cfg_r <= cfg_nxt;
      end
   end

   // Input being converted; autoscan starts on the positive input and
   // swaps per conversion; power down freezes it, saving the toggle
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         neg_sel_r <= 1'b0;
         scan_prev_r <= 1'b0;
      end
      else
      begin
         scan_prev_r <= (cfg_r.chan_mode == CHAN_SCAN);
         case (cfg_r.chan_mode)
            CHAN_NEG: neg_sel_r <= 1'b1;
            CHAN_SCAN:
            begin
               if (!scan_prev_r)
               begin
                  neg_sel_r <= 1'b0;
               end
               else if (i_conv_strobe && !cfg_r.power_down)
               begin
                  neg_sel_r <= ~neg_sel_r;
               end
            end
            default: neg_sel_r <= 1'b0;
         endcase
      end
   end

   // Bus handshakes stay live in power down; only conversion stops
   assign o_read_en = rd_act;
   assign o_write_taken = wr_take;
   assign o_cfg = cfg_r;
   assign o_sync_reset = sync_r;
   assign o_active_input = neg_sel_r;

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_reset);

   property p_input_write;
      take_input && !reset_fmt_r[DEVICE_RESET_BIT]
         |=> input_ref_r == $past(wdata);
   endproperty
   a_input_write: assert property (p_input_write)
      else $error("input register write not stored");

   property p_fmt_write;
      take_fmt && !wdata[DEVICE_RESET_BIT] |=> reset_fmt_r == $past(wdata);
   endproperty
   a_fmt_write: assert property (p_fmt_write)
      else $error("format register write not stored");

   property p_ref_select;
      take_input && !reset_fmt_r[DEVICE_RESET_BIT]
         |=> ##1 o_cfg.ref_external == $past(i_data[REF_SELECT_BIT], 2);
   endproperty
   a_ref_select: assert property (p_ref_select)
      else $error("reference select not applied");

   property p_pd_read;
      o_cfg.power_down && sel && !rw_style && !i_rd_n |-> o_read_en;
   endproperty
   a_pd_read: assert property (p_pd_read)
      else $error("read refused in power down");

   property p_single_ended;
      input_ref_r[CHAN_MSB:CHAN_LSB] == CHAN_CODE_NEG
         |=> o_cfg.chan_mode == CHAN_NEG;
   endproperty
   a_single_ended: assert property (p_single_ended)
      else $error("negative single-ended not decoded");

   property p_diff;
      input_ref_r[CHAN_MSB:CHAN_LSB] == CHAN_CODE_DIFF
         |=> o_cfg.chan_mode == CHAN_DIFF;
   endproperty
   a_diff: assert property (p_diff)
      else $error("differential code not decoded");

   property p_scan_alt;
      o_cfg.chan_mode == CHAN_SCAN && scan_prev_r && i_conv_strobe
         && !o_cfg.power_down |=> o_active_input != $past(o_active_input);
   endproperty
   a_scan_alt: assert property (p_scan_alt)
      else $error("autoscan did not alternate");

   property p_test_mid;
      input_ref_r[TEST_MSB:TEST_LSB] == 2'h2
         |=> o_cfg.conv_src == SRC_MID && o_cfg.test_active;
   endproperty
   a_test_mid: assert property (p_test_mid)
      else $error("midpoint test source not selected");

   property p_reset_default;
      $fell(i_reset) |-> input_ref_r == INPUT_REF_RESET;
   endproperty
   a_reset_default: assert property (p_reset_default)
      else $error("input register not at reset value");

   property p_dev_reset;
      take_fmt && wdata[DEVICE_RESET_BIT] |=> input_ref_r == INPUT_REF_RESET
         && reset_fmt_r[DEVICE_RESET_BIT] ##1 o_cfg.device_reset;
   endproperty
   a_dev_reset: assert property (p_dev_reset)
      else $error("device reset not applied");

   property p_sync_pulse;
      take_fmt && wdata[SYNC_RESET_BIT] |=> o_sync_reset ##1 !o_sync_reset;
   endproperty
   a_sync_pulse: assert property (p_sync_pulse)
      else $error("sync reset pulse wrong");

   property p_rw_style;
      rw_style && sel |-> o_read_en == i_wr_n;
   endproperty
   a_rw_style: assert property (p_rw_style)
      else $error("combined read/write decode wrong");

   property p_format;
      take_fmt && !wdata[DEVICE_RESET_BIT]
         |=> ##1 o_cfg.binary_format == $past(i_data[FORMAT_BIT], 2);
   endproperty
   a_format: assert property (p_format)
      else $error("output format not applied");

   property p_reserved_addr;
      wr_take && addr[1] |=> input_ref_r == $past(input_ref_r)
         && reset_fmt_r == $past(reset_fmt_r);
   endproperty
   a_reserved_addr: assert property (p_reserved_addr)
      else $error("reserved address changed a register");
endmodule

// *** tb/amc_host_model.sv ***
// Host bus model that drives the converter's parallel write pins
`timescale 1ns/1ps
module amc_host_model
(
   input wire logic i_clk_sys,
   input wire logic i_write_taken,
   input wire logic i_read_en,
   output logic [amc_pkg::BUS_W-1:0] o_data,
   output logic o_cs0_n,
   output logic o_cs1,
   output logic o_wr_n,
   output logic o_rd_n
);
   import amc_pkg::*;
   // Idle: deselected, both strobes high
   initial
   begin
      o_data = '0;
      o_cs0_n = 1'b1;
      o_cs1 = 1'b0;
      o_wr_n = 1'b1;
      o_rd_n = 1'b1;
   end
   // Both selects move together
   task automatic sel(input logic on);
      o_cs0_n = !on;
      o_cs1 = on;
   endtask
   // One word, register select in the top two bits
   task automatic write_word(input logic [1:0] a, input logic [9:0] v,
      output logic tk);
      @(negedge i_clk_sys);
      o_data = {a, v};
      sel(1'b1);
      o_wr_n = 1'b0;
      #5 tk = i_write_taken;
      @(negedge i_clk_sys);
      // Released bus shows the inverse, never the stale word
      o_data = ~{a, v};
      sel(1'b0);
      o_wr_n = 1'b1;
   endtask
   // Read cycle; write strobe stays high so no word is sent
   task automatic read_probe(input logic rd, output logic en);
      @(negedge i_clk_sys);
      sel(1'b1);
      o_rd_n = rd;
      #5 en = i_read_en;
      @(negedge i_clk_sys);
      sel(1'b0);
      o_rd_n = 1'b1;
   endtask
endmodule

// *** tb/amc_config_regs_tb.sv ***
// Self-checking bench of the converter configuration registers
`timescale 1ns/1ps
module amc_config_regs_tb;
   import amc_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_reset = 1'b1;
   logic i_conv_strobe = 1'b0;
   logic [BUS_W-1:0] data;
   logic cs0_n, cs1, wr_n, rd_n;
   amc_cfg_t cfg;
   logic sync_rst, read_en, taken, act_in;
   logic tk;
   // Set while input writes are expected to be refused
   logic hold = 1'b0;
   int failures = 0;
   int checks = 0;
   // Input register words: every defined channel code, test source and flag
   logic [9:0] tbl [10] = '{10'h000, 10'h008, 10'h020, 10'h088,
      10'h00d, 10'h001, 10'h004, 10'h120, 10'h220, 10'h320};
   always #10 i_clk_sys = ~i_clk_sys;
   amc_config_regs dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
      .i_data(data), .i_cs0_n(cs0_n), .i_cs1(cs1), .i_wr_n(wr_n),
      .i_rd_n(rd_n), .i_conv_strobe(i_conv_strobe), .o_cfg(cfg),
      .o_sync_reset(sync_rst), .o_read_en(read_en),
      .o_write_taken(taken), .o_active_input(act_in));
   amc_host_model host (.i_clk_sys(i_clk_sys), .i_write_taken(taken),
      .i_read_en(read_en), .o_data(data), .o_cs0_n(cs0_n), .o_cs1(cs1),
      .o_wr_n(wr_n), .o_rd_n(rd_n));
   // Expected decode, reckoned from the bit layout alone
   function automatic amc_cfg_t exp_cfg(input logic [9:0] a,
      input logic [9:0] b);
      amc_cfg_t c;
      c = '0;
      c.ref_external = a[0];
      c.power_down = a[2];
      case (a[7:3])
         CHAN_CODE_POS: c.chan_mode = CHAN_POS;
         CHAN_CODE_NEG: c.chan_mode = CHAN_NEG;
         CHAN_CODE_DIFF: c.chan_mode = CHAN_DIFF;
         CHAN_CODE_SCAN: c.chan_mode = CHAN_SCAN;
         default: c.chan_mode = CHAN_RSVD;
      endcase
      c.conv_src = amc_conv_src_t'(a[9:8]);
      c.test_active = |a[9:8];
      c.binary_format = b[7];
      c.offset_cal = b[8];
      c.rw_combined = b[6];
      c.device_reset = b[0];
      return c;
   endfunction
   // Four-state compare; an unknown matches only an unknown in the same bit
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic see(input logic [9:0] a, input logic [9:0] b);
      chk({4'b0, cfg}, {4'b0, exp_cfg(a, b)});
   endtask
   // Write, then follow the sync pulse; returns when o_cfg has settled
   task automatic put(input logic [1:0] a, input logic [9:0] v);
      host.write_word(a, v, tk);
      // Taken flag on reserved or refused words is left open
      if (!a[1] && !hold)
         chk(tk, 1'b1);
      chk(sync_rst, a == ADDR_RESET_FMT && v[1]);
      @(negedge i_clk_sys);
      chk(sync_rst, 1'b0);
   endtask
   task automatic do_reset;
      @(negedge i_clk_sys);
      i_reset = 1'b1;
      repeat (20) @(negedge i_clk_sys);
      i_reset = 1'b0;
      see(INPUT_REF_RESET, RESET_FMT_RESET);
      chk(act_in, 1'b0);
      $display("Test reset done");
   endtask
   // One conversion pulse, then let the toggle land
   task automatic pulse;
      @(negedge i_clk_sys);
      i_conv_strobe = 1'b1;
      @(negedge i_clk_sys);
      i_conv_strobe = 1'b0;
      @(negedge i_clk_sys);
   endtask
   initial
   begin
      do_reset();
      // Sync generator reset is set while configuring, before any autoscan
      put(ADDR_RESET_FMT, 10'h032);
      foreach (tbl[i])
      begin
         put(ADDR_INPUT_REF, tbl[i]);
         see(tbl[i], RESET_FMT_RESET);
      end
      put(2'h2, 10'h3ff);
      put(2'h3, 10'h000);
      see(tbl[9], RESET_FMT_RESET);
      $display("Test input register done");
      put(ADDR_RESET_FMT, 10'h032);
      put(ADDR_INPUT_REF, 10'h088);
      chk(act_in, 1'b0);
      pulse();
      chk(act_in, 1'b1);
      pulse();
      chk(act_in, 1'b0);
      // Powered down: no alternation, yet the bus still answers
      put(ADDR_INPUT_REF, 10'h08c);
      pulse();
      chk(act_in, 1'b0);
      host.read_probe(1'b0, tk);
      chk(tk, 1'b1);
      host.read_probe(1'b1, tk);
      chk(tk, 1'b0);
      $display("Test autoscan done");
      put(ADDR_RESET_FMT, 10'h1c0);
      see(10'h08c, 10'h1c0);
      host.read_probe(1'b1, tk);
      chk(tk, 1'b1);
      put(ADDR_RESET_FMT, 10'h002);
      see(10'h08c, 10'h002);
      $display("Test format register done");
      put(ADDR_RESET_FMT, 10'h001);
      see(INPUT_REF_RESET, 10'h031);
      hold = 1'b1;
      put(ADDR_INPUT_REF, 10'h008);
      see(INPUT_REF_RESET, 10'h031);
      hold = 1'b0;
      put(ADDR_RESET_FMT, 10'h000);
      put(ADDR_INPUT_REF, 10'h008);
      see(10'h008, 10'h000);
      // Input selection follows the decoded mode one cycle later
      @(negedge i_clk_sys);
      chk(act_in, 1'b1);
      $display("Test device reset done");
      do_reset();
      end_sim();
   end
   // Whole run needs under 130 cycles; this allows 5000
   initial
   begin
      #100000;
      failures++;
      end_sim();
   end
endmodule
